/* File: src/aars_pkg.sv */
// constants and types for the amplifier reset and start-up sequencer
package aars_pkg;
    // ==========================================
    // timing
    localparam int CLK_NS = 10;
    localparam int LOCK_US = 1000;
    localparam int PLL_US = 10000;
    localparam int LOCK_CYC = LOCK_US * 1000 / CLK_NS;
    localparam int PLL_CYC = PLL_US * 1000 / CLK_NS;
    // ==========================================
    // control bus address and register offsets
    localparam logic [7:0] DEV_ADDR = 8'h30;
    localparam logic [7:0] REG_PAGE = 8'h00;
    localparam logic [7:0] PAGE_0 = 8'h00;
    localparam logic [7:0] PAGE_1 = 8'h01;
    localparam logic [7:0] COEF_PAGE = 8'h2C;
    localparam logic [7:0] P0_SWRST = 8'h01;
    localparam logic [7:0] P0_CLKSEL = 8'h04;
    localparam logic [7:0] P0_PLL = 8'h05;
    localparam logic [7:0] P0_DAC_CLOCK_DIVIDER_N = 8'h0B;
    localparam logic [7:0] P0_DAC_CLOCK_DIVIDER_M = 8'h0C;
    localparam logic [7:0] P0_DAC_OVERSAMPLING_RATIO_HI = 8'h0D;
    localparam logic [7:0] P0_DAC_OVERSAMPLING_RATIO_LO = 8'h0E;
    localparam logic [7:0] P1_HPPWR = 8'h09;
    localparam logic [7:0] P1_CM = 8'h0A;
    localparam logic [7:0] P1_HPFLT = 8'h0B;
    localparam logic [7:0] P1_SPKPWR = 8'h2D;
    // ==========================================
    // field positions and encodings
    localparam int SWRST_BIT = 0;
    localparam int PLL_PWR_BIT = 7;
    localparam int DIV_PWR_BIT = 7;
    localparam int HP_PWR_BIT = 5;
    localparam int CM_BIT = 6;
    localparam int HPFLT_BIT = 0;
    localparam int SPK_PWR_BIT = 1;
    localparam logic [1:0] CLKSEL_PLL = 2'h3;
    // ==========================================
    // types
    typedef enum logic [2:0] {
        FSM_HOLD = 3'b001,
        FSM_INIT = 3'b010,
        FSM_RUN = 3'b100
    } aars_fsm_t;

    typedef struct packed {
        logic valid;
        logic [7:0] dev;
        logic [7:0] addr;
        logic [7:0] data;
    } aars_acc_t;

    typedef struct packed {
        logic lockout;
        logic procClkOn;
        logic pllLocked;
        logic hpOn;
        logic spkOn;
        logic hpFault;
        logic spkFault;
        logic cmLow;
        logic [7:0] page;
        logic [1:0] clkSel;
        logic [7:0] pllCfg;
        logic [7:0] dac_clock_divider_n;
        logic [7:0] dac_clock_divider_m;
        logic [9:0] dac_oversampling_ratio;
        logic [7:0] hpCtl;
        logic [7:0] spkCtl;
        logic ack;
        logic refused;
    } aars_stat_t;
endpackage

/* File: src/aars_reset_seq.sv */
// reset, lockout and start-up sequencing core of the amplifier
`timescale 1ns/1ps
module aars_reset_seq #(
    parameter int LOCK_CYCLES = aars_pkg::LOCK_CYC,
    parameter int PLL_CYCLES = aars_pkg::PLL_CYC,
    parameter int COEF_DEPTH = 128
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic porOk,
    input wire logic rstPinN,
    input wire logic hpShort,
    input wire logic spkOvercurrent,
    input wire aars_pkg::aars_acc_t acc,
    output aars_pkg::aars_stat_t stat,
    output logic [7:0] rdData
);
    import aars_pkg::*;

    localparam int MAXC = (PLL_CYCLES > LOCK_CYCLES) ? PLL_CYCLES : LOCK_CYCLES;
    localparam int CW = $clog2(MAXC + 1);
    localparam int AW = $clog2(COEF_DEPTH);

    typedef struct packed {
        aars_fsm_t fsm;
        logic swRst;
        logic [CW-1:0] lockCnt;
        logic [CW-1:0] pllCnt;
        logic [AW-1:0] initIdx;
        logic initDone;
        aars_stat_t st;
    } aars_state_t;

    // everything powered down and locked out, as after any reset
    localparam aars_state_t S_RST = '{fsm: FSM_HOLD, st: '{lockout: 1'b1, default: '0},
        default: '0};

    aars_state_t s_reg;
    aars_state_t s_next;
    logic hit;
    logic isWr;
    logic isCoef;
    logic intRst;
    logic initWe;
    logic coefWe;
    logic coefRe;
    logic [7:0] coefMem [COEF_DEPTH];

    function automatic logic regHit(input logic wr, input logic [7:0] pg,
                                    input logic [7:0] curPg, input logic [7:0] ad,
                                    input logic [7:0] want);
        regHit = wr && curPg == pg && ad == want;
    endfunction

    // ==========================================
    // next state
    always_comb
    begin
        s_next = s_reg;
        s_next.st.ack = 1'b0;
        s_next.st.refused = 1'b0;
        s_next.swRst = 1'b0;
        initWe = 1'b0;
        coefWe = 1'b0;
        coefRe = 1'b0;
        intRst = !porOk || !rstPinN || s_reg.swRst;
        hit = acc.valid && acc.dev[7:1] == DEV_ADDR[7:1] && s_reg.fsm != FSM_HOLD;
        isWr = hit && !acc.dev[0];
        isCoef = hit && s_reg.st.page >= COEF_PAGE && acc.addr != REG_PAGE
            && {1'b0, acc.addr} < 9'(COEF_DEPTH);
        case (s_reg.fsm)
            FSM_HOLD:
            begin
                s_next.fsm = FSM_INIT;
            end
            FSM_INIT:
            begin
                // clear the coefficient buffer one word a cycle
                initWe = !s_reg.initDone;
                s_next.initIdx = AW'(s_reg.initIdx + 1'b1);
                if (s_reg.initIdx == AW'(COEF_DEPTH - 1))
                begin
                    s_next.initDone = 1'b1;
                end
                s_next.lockCnt = CW'(s_reg.lockCnt + 1'b1);
                if (s_reg.lockCnt == CW'(LOCK_CYCLES - 1))
                begin
                    s_next.fsm = FSM_RUN;
                    s_next.st.lockout = 1'b0;
                end
            end
            FSM_RUN:
            begin
                s_next.fsm = FSM_RUN;
            end
            default:
            begin
                s_next = S_RST;
            end
        endcase
        if (hit)
        begin
            s_next.st.ack = 1'b1;
        end
        if (isCoef)
        begin
            if (s_reg.st.lockout)
            begin
                s_next.st.refused = 1'b1;
            end
            else
            begin
                coefWe = isWr;
                coefRe = !isWr;
            end
        end
        else if (isWr && acc.addr == REG_PAGE)
        begin
            s_next.st.page = acc.data;
        end
        else if (isWr)
        begin
            if (regHit(1'b1, PAGE_0, s_reg.st.page, acc.addr, P0_SWRST))
            begin
                s_next.swRst = acc.data[SWRST_BIT];
            end
            if (regHit(1'b1, PAGE_0, s_reg.st.page, acc.addr, P0_CLKSEL))
            begin
                s_next.st.clkSel = acc.data[1:0];
            end
            if (regHit(1'b1, PAGE_0, s_reg.st.page, acc.addr, P0_PLL))
            begin
                s_next.st.pllCfg = acc.data;
            end
            // D7 gates the divider, D6-D0 the ratio
            if (regHit(1'b1, PAGE_0, s_reg.st.page, acc.addr, P0_DAC_CLOCK_DIVIDER_N))
            begin
                s_next.st.dac_clock_divider_n = acc.data;
            end
            if (regHit(1'b1, PAGE_0, s_reg.st.page, acc.addr, P0_DAC_CLOCK_DIVIDER_M))
            begin
                s_next.st.dac_clock_divider_m = acc.data;
            end
            if (regHit(1'b1, PAGE_0, s_reg.st.page, acc.addr, P0_DAC_OVERSAMPLING_RATIO_HI))
            begin
                s_next.st.dac_oversampling_ratio[9:8] = acc.data[1:0];
            end
            if (regHit(1'b1, PAGE_0, s_reg.st.page, acc.addr, P0_DAC_OVERSAMPLING_RATIO_LO))
            begin
                s_next.st.dac_oversampling_ratio[7:0] = acc.data;
            end
            if (regHit(1'b1, PAGE_1, s_reg.st.page, acc.addr, P1_HPPWR))
            begin
                s_next.st.hpCtl = acc.data;
                if (acc.data[HP_PWR_BIT])
                begin
                    s_next.st.hpFault = 1'b0;
                end
            end
            if (regHit(1'b1, PAGE_1, s_reg.st.page, acc.addr, P1_CM))
            begin
                s_next.st.cmLow = acc.data[CM_BIT];
            end
            if (regHit(1'b1, PAGE_1, s_reg.st.page, acc.addr, P1_SPKPWR))
            begin
                s_next.st.spkCtl = acc.data;
                if (acc.data[SPK_PWR_BIT])
                begin
                    s_next.st.spkFault = 1'b0;
                end
            end
        end
        // a fault in the same cycle as its clear stays latched
        if (hpShort)
        begin
            s_next.st.hpFault = 1'b1;
        end
        if (spkOvercurrent)
        begin
            s_next.st.spkFault = 1'b1;
        end
        // power-down only gates the stage; settings stay put
        s_next.st.hpOn = s_next.st.hpCtl[HP_PWR_BIT] && !s_next.st.hpFault;
        s_next.st.spkOn = s_next.st.spkCtl[SPK_PWR_BIT] && !s_next.st.spkFault;
        if (s_next.st.pllCfg[PLL_PWR_BIT] && s_next.st.clkSel == CLKSEL_PLL)
        begin
            if (!s_reg.st.pllLocked)
            begin
                s_next.pllCnt = CW'(s_reg.pllCnt + 1'b1);
                s_next.st.pllLocked = s_reg.pllCnt == CW'(PLL_CYCLES - 1);
            end
        end
        else
        begin
            s_next.pllCnt = '0;
            s_next.st.pllLocked = 1'b0;
        end
        s_next.st.procClkOn = s_next.st.clkSel != CLKSEL_PLL || s_next.st.pllLocked;
        if (intRst)
        begin
            s_next = S_RST;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_reg <= S_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ==========================================
    // coefficient buffer, shared by all coefficient pages
    always_ff @(posedge clk)
    begin
        if (initWe)
        begin
            coefMem[s_reg.initIdx] <= 8'h00;
        end
        else if (coefWe)
        begin
            coefMem[acc.addr[AW-1:0]] <= acc.data;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdData <= 8'h00;
        end
        else if (coefRe)
        begin
            rdData <= coefMem[acc.addr[AW-1:0]];
        end
    end

    assign stat = s_reg.st;

    // ==========================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_por;
        !porOk |=> stat.lockout && !stat.hpOn && !stat.spkOn && !stat.pllLocked;
    endproperty
    a_por: assert property (p_por) else $error("no reset on power-on detect");

    property p_pin;
        !rstPinN |=> stat.page == 8'h00 && stat.lockout && s_reg.fsm == FSM_HOLD;
    endproperty
    a_pin: assert property (p_pin) else $error("reset pin ignored");

    property p_swrst;
        regHit(isWr, PAGE_0, s_reg.st.page, acc.addr, P0_SWRST) && acc.data[0] && !intRst
            |=> s_reg.swRst ##1 stat.lockout && stat.clkSel == 2'h0;
    endproperty
    a_swrst: assert property (p_swrst) else $error("software reset lost");

    property p_lockend;
        $fell(stat.lockout) |-> $past(s_reg.lockCnt) == CW'(LOCK_CYCLES - 1);
    endproperty
    a_lockend: assert property (p_lockend) else $error("lockout length wrong");

    property p_pll;
        $rose(stat.pllLocked) |-> $past(s_reg.pllCnt) == CW'(PLL_CYCLES - 1);
    endproperty
    a_pll: assert property (p_pll) else $error("pll lock delay wrong");

    property p_hpshort;
        hpShort && !intRst |=> stat.hpFault && !stat.hpOn;
    endproperty
    a_hpshort: assert property (p_hpshort) else $error("hp short not latched");

    property p_hpreset;
        regHit(isWr, PAGE_1, s_reg.st.page, acc.addr, P1_HPPWR) && acc.data[5]
            && !hpShort && !intRst && !isCoef |=> stat.hpOn && !stat.hpFault;
    endproperty
    a_hpreset: assert property (p_hpreset) else $error("hp stage reset failed");

    property p_spkreset;
        regHit(isWr, PAGE_1, s_reg.st.page, acc.addr, P1_SPKPWR) && acc.data[1]
            && !spkOvercurrent && !intRst && !isCoef |=> stat.spkOn && !stat.spkFault;
    endproperty
    a_spkreset: assert property (p_spkreset) else $error("spk stage reset failed");

    property p_page;
        isWr && !isCoef && acc.addr == REG_PAGE && !intRst |=> stat.page == $past(acc.data);
    endproperty
    a_page: assert property (p_page) else $error("page select lost");

    property p_lockref;
        isCoef && stat.lockout && !intRst |=> stat.refused;
    endproperty
    a_lockref: assert property (p_lockref) else $error("coef access not refused");

    property p_cm;
        regHit(isWr, PAGE_1, s_reg.st.page, acc.addr, P1_CM) && !intRst && !isCoef
            |=> stat.cmLow == $past(acc.data[6]);
    endproperty
    a_cm: assert property (p_cm) else $error("common mode not stored");

    c_lockdone: cover property ($fell(stat.lockout));
    c_pllup: cover property ($rose(stat.pllLocked));
    c_hprecover: cover property (stat.hpFault ##[1:20] stat.hpOn);
endmodule // aars_reset_seq

/* File: dv/aars_host_model.sv */
// host controller model: supplies status, reset pin and control-bus accesses
`timescale 1ns/1ps
module aars_host_model (
    input wire logic clk,
    input wire aars_pkg::aars_stat_t stat,
    output aars_pkg::aars_acc_t acc,
    output logic rstPinN,
    output logic porOk
);
    import aars_pkg::*;
    // ==========================================
    // supplies ramp with the reset pin held low
    initial
    begin
        acc = '0;
        porOk = 1'b0;
        rstPinN = 1'b0;
    end
    task automatic power_up();
        @(posedge clk);
        porOk <= 1'b1;
        @(posedge clk);
        rstPinN <= 1'b1;
        #1;
    endtask
    // pin, or power-on detect when usePor is set, low for one full cycle, above the minimum width
    task automatic pulse_reset(input bit usePor);
        @(posedge clk);
        porOk <= !usePor;
        rstPinN <= usePor;
        @(posedge clk);
        porOk <= 1'b1;
        rstPinN <= 1'b1;
        #1;
    endtask
    // ==========================================
    // one access; early skips the start-up hold-off on purpose
    task automatic access(input logic [7:0] dev, input logic [7:0] ad,
        input logic [7:0] dat, input bit early);
        int n;
        n = 0;
        while (!early && stat.lockout !== 1'b0 && n < 5000)
        begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        acc <= '{1'b1, dev, ad, dat};
        @(posedge clk);
        // released lines show no stale value
        acc <= '{1'b0, ~dev, ~ad, ~dat};
        #1;
    endtask
    task automatic settle(input int cycles);
        repeat (cycles) @(posedge clk);
        #1;
    endtask
endmodule // aars_host_model

/* File: dv/aars_reset_seq_bench.sv */
// self-checking bench for the reset and start-up sequencer
`timescale 1ns/1ps
module aars_reset_seq_bench;
    import aars_pkg::*;
    localparam int LOCK_N = 130;
    localparam int PLL_N = 20;
    localparam logic [7:0] WR = DEV_ADDR;
    localparam logic [7:0] RD = DEV_ADDR | 8'h01;
    logic clk;
    logic resetn;
    logic hpShort;
    logic spkOvercurrent;
    logic rstPinN;
    logic porOk;
    logic [7:0] rdData;
    aars_acc_t acc;
    aars_stat_t stat;
    int mismatches;
    int check_count;
    int n;

    aars_reset_seq #(.LOCK_CYCLES(LOCK_N), .PLL_CYCLES(PLL_N), .COEF_DEPTH(128)) dut_u (
        .clk(clk), .resetn(resetn), .porOk(porOk), .rstPinN(rstPinN), .hpShort(hpShort),
        .spkOvercurrent(spkOvercurrent), .acc(acc), .stat(stat), .rdData(rdData));
    aars_host_model host_u (.clk(clk), .stat(stat), .acc(acc), .rstPinN(rstPinN),
        .porOk(porOk));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========================================
    // helpers
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] dat);
        host_u.access(WR, ad, dat, 1'b0);
        check("ack", 10'(1), 10'(stat.ack));
    endtask
    task automatic defaults();
        check("lockout", 10'(1), 10'(stat.lockout));
        check("page", 10'(0), 10'(stat.page));
        check("power", 10'(0), 10'({stat.hpOn, stat.spkOn, stat.pllLocked, stat.hpFault}));
        check("regs", 10'(0), 10'(stat.dac_clock_divider_n | stat.pllCfg | stat.hpCtl | 8'(stat.cmLow)));
        check("regs2", 10'(0), stat.dac_oversampling_ratio | {stat.clkSel, stat.dac_clock_divider_m} | 10'(stat.spkCtl));
    endtask
    task automatic wait_lock();
        n = 0;
        while (stat.lockout !== 1'b0 && n < LOCK_N + 10)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic pulse(input bit spk);
        @(posedge clk);
        hpShort <= !spk;
        spkOvercurrent <= spk;
        @(posedge clk);
        hpShort <= 1'b0;
        spkOvercurrent <= 1'b0;
        #1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ==========================================
    // tests
    initial
    begin
        resetn = 1'b0;
        hpShort = 1'b0;
        spkOvercurrent = 1'b0;
        mismatches = 0;
        check_count = 0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        host_u.power_up();
        defaults();
        wait_lock();
        check("lock span", 10'(1), 10'(n >= LOCK_N && n <= LOCK_N + 2));
        $display("test startup done");
        wr(REG_PAGE, PAGE_1);
        check("page", 10'(PAGE_1), 10'(stat.page));
        host_u.access(8'h32, REG_PAGE, PAGE_0, 1'b0);
        check("foreign ack", 10'(0), 10'({stat.ack, stat.page != PAGE_1}));
        wr(P1_CM, 8'h40);
        check("cm", 10'(1), 10'(stat.cmLow));
        wr(P1_HPPWR, 8'h20);
        check("hp on", 10'h120, {1'b0, stat.hpOn, stat.hpCtl});
        pulse(1'b0);
        check("hp short", 10'h220, {stat.hpFault, stat.hpOn, stat.hpCtl});
        wr(P1_HPPWR, 8'h20);
        check("hp reset", 10'h101, {stat.hpFault, stat.hpOn, 7'h0, stat.cmLow});
        wr(P1_SPKPWR, 8'h02);
        check("spk on", 10'(1), 10'(stat.spkOn));
        pulse(1'b1);
        check("spk oc", 10'h201, {stat.spkFault, stat.spkOn, 7'h0, stat.hpOn});
        check("spk ctl", 10'h002, 10'(stat.spkCtl));
        wr(P1_SPKPWR, 8'h02);
        check("spk reset", 10'h100, {stat.spkFault, stat.spkOn, 8'h0});
        wr(P1_SPKPWR, 8'h00);
        check("spk off", 10'h020, {stat.spkOn, 1'b0, stat.hpCtl});
        $display("test power stages done");
        wr(REG_PAGE, PAGE_0);
        wr(P0_CLKSEL, 8'h03);
        wr(P0_PLL, 8'h91);
        check("pll cfg", 10'h391, {stat.clkSel, stat.pllCfg});
        host_u.settle(PLL_N - 3);
        check("pll early", 10'(0), 10'({stat.pllLocked, stat.procClkOn}));
        host_u.settle(5);
        check("pll lock", 10'(3), 10'({stat.pllLocked, stat.procClkOn}));
        wr(P0_DAC_CLOCK_DIVIDER_N, 8'h84);
        wr(P0_DAC_CLOCK_DIVIDER_M, 8'h82);
        wr(P0_DAC_OVERSAMPLING_RATIO_HI, 8'h01);
        wr(P0_DAC_OVERSAMPLING_RATIO_LO, 8'h80);
        check("dac_clock_divider_n", 10'h084, 10'(stat.dac_clock_divider_n));
        check("dac_clock_divider_m", 10'h082, 10'(stat.dac_clock_divider_m));
        check("osr", 10'h180, stat.dac_oversampling_ratio);
        wr(P0_DAC_OVERSAMPLING_RATIO_HI, 8'hFE);
        check("osr hi", 10'h280, stat.dac_oversampling_ratio);
        wr(P0_SWRST, 8'h01);
        @(posedge clk);
        #1;
        defaults();
        $display("test clocks and soft reset done");
        for (int i = 0; i < 2; i++)
        begin
            wr(REG_PAGE, PAGE_1);
            wr(P1_HPPWR, 8'h20);
            check("hp loop", 10'h120, {1'b0, stat.hpOn, stat.hpCtl});
            host_u.pulse_reset(i[0]);
            defaults();
            host_u.access(WR, REG_PAGE, COEF_PAGE, 1'b1);
            host_u.access(WR, 8'h05, 8'hAA, 1'b1);
            check("refused", 10'(1), 10'(stat.refused));
            wait_lock();
            host_u.access(RD, 8'h05, 8'h00, 1'b0);
            check("coef init", 10'(0), 10'(rdData));
            host_u.access(WR, 8'h05, 8'h5A, 1'b0);
            host_u.access(RD, 8'h05, 8'h00, 1'b0);
            check("coef data", 10'h05A, 10'(rdData));
            $display("test hardware reset %0d done", i);
        end
        report_and_stop();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
endmodule // aars_reset_seq_bench
